// [hdl/ucs_pkg.sv]
package ucs_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] UCS_IDX_SYS_CTRL   = 8'h11;
	localparam logic [7:0] UCS_IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] UCS_IDX_IRQ_MASK   = 8'h21;
	localparam logic [7:0] UCS_IDX_FEATURE    = 8'h22;
	localparam logic [7:0] UCS_IDX_CTRL_STAT  = 8'h23;

	// Field positions of system_control.
	localparam int UCS_SC_POLARITY  = 7;
	localparam int UCS_SC_RWU_EN    = 6;
	localparam int UCS_SC_SUSP_IE   = 5;
	localparam int UCS_SC_RESET_IE  = 4;
	localparam int UCS_SC_SOFT_RST  = 3;
	localparam int UCS_SC_PULSE_SEL = 2;
	localparam int UCS_SC_GLOBAL_IE = 1;

	// Field positions of the feature register.
	localparam int UCS_FT_EXT_FEAT  = 0;
	localparam int UCS_FT_SUSP_PO   = 1;
	localparam int UCS_FT_SUSP_LOE  = 2;

	// Sticky event bits of the status and mask registers.
	localparam int UCS_EV_WAKE_DONE = 0;
	localparam int UCS_EV_PIN_IRQ   = 1;
	localparam int UCS_EV_IGNORED   = 2;
	localparam int UCS_EV_WIDTH     = 3;

	// Values after reset.
	localparam logic [7:0]            UCS_SC_RESET   = 8'h00;
	localparam logic [2:0]            UCS_FT_RESET   = 3'h0;
	localparam logic [UCS_EV_WIDTH-1:0] UCS_EV_RESET = 3'h0;

	// Pulse mode holds the interrupt pin active for this many clock periods.
	localparam logic [1:0] UCS_PULSE_CYCLES = 2'h2;

	// Wake-up sequencer states.
	typedef enum logic [1:0] {
		UCS_ST_IDLE   = 2'b01,
		UCS_ST_WAKING = 2'b10
	} ucs_wake_st_t;

endpackage

// [hdl/ucs_irq_pin.sv]
`timescale 1ns/1ns
module ucs_irq_pin (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic src_any,
	input  wire logic pulse_mode,
	input  wire logic polarity,
	output logic      pin,
	output logic      active
);
	import ucs_pkg::*;

	logic       src_q;
	logic       src_d;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       act_q;
	logic       act_d;
	logic       pin_q;
	logic       pin_d;
	logic       rise;

	// Next state: in pulse mode a new source edge reloads the pulse counter.
	always_comb begin
		src_d = src_any;
		rise  = src_any & ~src_q;
		if (rise && pulse_mode) begin
			cnt_d = UCS_PULSE_CYCLES;
		end else if (cnt_q != 2'h0) begin
			cnt_d = cnt_q - 2'h1;
		end else begin
			cnt_d = 2'h0;
		end
		act_d = pulse_mode ? (cnt_d != 2'h0) : src_any;
		pin_d = polarity ? act_d : ~act_d;
	end

	// Registers; the pin idles high because the default polarity is active-low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= 1'b0;
			cnt_q <= 2'h0;
			act_q <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			src_q <= src_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			pin_q <= pin_d;
		end
	end

	assign pin    = pin_q;
	assign active = act_q;

	sequence s_pulse_start;
		rise && pulse_mode && !cnt_q[1];
	endsequence

	a_pulse_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
		s_pulse_start ##1 pulse_mode |-> act_q ##1 act_q ##1 (!act_q || $past(rise)))
		else $error("pulse mode active time is not two clocks");

	a_level_follow: assert property (@(posedge pclk) disable iff (!presetn)
		!pulse_mode |=> (act_q == $past(src_any)))
		else $error("level mode output does not follow sources");

	a_pin_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		$stable(polarity) |-> (pin_q == (polarity ? act_q : !act_q)))
		else $error("interrupt pin level disagrees with polarity");

endmodule

// [hdl/ucs_wake.sv]
`timescale 1ns/1ns
module ucs_wake (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic soft_write_one,
	input  wire logic suspended,
	input  wire logic ext_feature,
	input  wire logic susp_power_off,
	input  wire logic susp_low_out,
	input  wire logic local_wakeup_req,
	input  wire logic remote_wakeup_enable,
	output logic      wake_req,
	output logic      resume_signal,
	output logic      soft_reset_bit_set,
	output logic      ignored,
	output logic      waking,
	output logic      remote_wakeup_request_flag
);
	import ucs_pkg::*;

	ucs_wake_st_t st_q;
	ucs_wake_st_t st_d;
	logic         wake_q, wake_d;
	logic         res_q, res_d;
	logic         set_q, set_d;
	logic         ign_q, ign_d;
	logic         rwr_q, rwr_d;
	logic         allowed;

	// Next state of the soft-reset and remote wake-up sequencer.
	always_comb begin
		allowed = ext_feature & ~susp_power_off & ~susp_low_out;
		st_d    = st_q;
		wake_d  = 1'b0;
		res_d   = 1'b0;
		set_d   = 1'b0;
		ign_d   = 1'b0;
		rwr_d   = rwr_q & suspended;
		unique case (st_q)
			UCS_ST_IDLE: begin
				if (soft_write_one && !suspended) begin
					set_d = 1'b1;
				end else if (soft_write_one && allowed) begin
					wake_d = 1'b1;
					st_d   = UCS_ST_WAKING;
				end else if (soft_write_one) begin
					ign_d = 1'b1;
				end else if (local_wakeup_req && remote_wakeup_enable && suspended) begin
					wake_d = 1'b1;
					res_d  = 1'b1;
					rwr_d  = 1'b1;
				end
			end
			UCS_ST_WAKING: begin
				if (!suspended) begin
					set_d = 1'b1;
					st_d  = UCS_ST_IDLE;
				end
			end
		endcase
	end

	// Registers of the sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= UCS_ST_IDLE;
			wake_q <= 1'b0;
			res_q  <= 1'b0;
			set_q  <= 1'b0;
			ign_q  <= 1'b0;
			rwr_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			wake_q <= wake_d;
			res_q  <= res_d;
			set_q  <= set_d;
			ign_q  <= ign_d;
			rwr_q  <= rwr_d;
		end
	end

	assign wake_req                   = wake_q;
	assign resume_signal              = res_q;
	assign soft_reset_bit_set                 = set_q;
	assign ignored                    = ign_q;
	assign waking                     = (st_q == UCS_ST_WAKING);
	assign remote_wakeup_request_flag = rwr_q;

	sequence s_soft_wake;
		soft_write_one && suspended && allowed && (st_q == UCS_ST_IDLE);
	endsequence

	a_soft_wake_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		s_soft_wake |=> wake_q && !res_q && !rwr_q)
		else $error("soft reset wake sent resume or set request flag");

	a_set_deferred: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == UCS_ST_WAKING) && suspended |=> !set_q)
		else $error("soft reset bit set before the device resumed");

	a_set_after_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == UCS_ST_WAKING) && !suspended |=> set_q && (st_q == UCS_ST_IDLE))
		else $error("soft reset bit not set after wake-up");

endmodule

// [hdl/ucs_sys_ctrl.sv]
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module ucs_sys_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ep_flag_any,
	input  wire logic        missed_frame_start_flag,
	input  wire logic        bus_reset_flag,
	input  wire logic        suspend_flag,
	input  wire logic        suspended,
	input  wire logic        local_wakeup_req,
	output logic             interrupt_output_pin,
	output logic             ctrl_reset,
	output logic             wake_req,
	output logic             resume_signal,
	output logic             irq
);
	import ucs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic       access;
	logic       setup;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic       hit_sc;
	logic       hit_st;
	logic       hit_mk;
	logic       hit_ft;
	logic       hit_cs;
	logic       mapped;

	// The slave always answers in the first access cycle.
	always_comb begin
		idx    = paddr[9:2];
		hit_sc = (idx == UCS_IDX_SYS_CTRL);
		hit_st = (idx == UCS_IDX_IRQ_STATUS);
		hit_mk = (idx == UCS_IDX_IRQ_MASK);
		hit_ft = (idx == UCS_IDX_FEATURE);
		hit_cs = (idx == UCS_IDX_CTRL_STAT);
		mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && (hit_sc | hit_st | hit_mk | hit_ft | hit_cs);
		setup  = psel & ~penable;
		access = psel & penable;
		wr     = access & pwrite & mapped;
		rd     = access & ~pwrite & mapped;
	end

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Registers written by software.

	logic [7:0]              sc_q, sc_d;
	logic                    srst_q, srst_d;
	logic [2:0]              ft_q, ft_d;
	logic [UCS_EV_WIDTH-1:0] mk_q, mk_d;
	logic [UCS_EV_WIDTH-1:0] st_q, st_d;
	logic                    soft_write_one;
	logic                    soft_reset_bit_set;
	logic                    ignored;
	logic                    waking;
	logic                    rwr_flag;
	logic                    pin_active;
	logic                    pin_active_q, pin_active_d;
	logic [UCS_EV_WIDTH-1:0] events;
	logic [31:0]             rdata_q, rdata_d;

	// Control register, feature register, mask and soft reset bit.
	always_comb begin
		sc_d           = sc_q;
		ft_d           = ft_q;
		mk_d           = mk_q;
		srst_d         = srst_q;
		soft_write_one = 1'b0;
		if (wr && hit_sc) begin
			sc_d = pwdata[7:0] & 8'hF6;
			if (pwdata[UCS_SC_SOFT_RST]) begin
				soft_write_one = 1'b1;
			end else begin
				srst_d = 1'b0;
			end
		end
		if (wr && hit_ft) begin
			ft_d = pwdata[2:0];
		end
		if (wr && hit_mk) begin
			mk_d = pwdata[UCS_EV_WIDTH-1:0];
		end
		if (soft_reset_bit_set) begin
			srst_d = 1'b1;
		end
	end

	// The control register itself survives soft reset so software can release it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_q   <= UCS_SC_RESET;
			srst_q <= 1'b0;
			ft_q   <= UCS_FT_RESET;
			mk_q   <= UCS_EV_RESET;
		end else begin
			sc_q   <= sc_d;
			srst_q <= srst_d;
			ft_q   <= ft_d;
			mk_q   <= mk_d;
		end
	end

	assign ctrl_reset = srst_q;

	////////////////////////////////////////////////////////////////////////////////
	// Soft reset wake-up sequencer.

	ucs_wake u_wake (
		.pclk                       (pclk),
		.presetn                    (presetn),
		.soft_write_one             (soft_write_one),
		.suspended                  (suspended),
		.ext_feature                (ft_q[UCS_FT_EXT_FEAT]),
		.susp_power_off             (ft_q[UCS_FT_SUSP_PO]),
		.susp_low_out               (ft_q[UCS_FT_SUSP_LOE]),
		.local_wakeup_req           (local_wakeup_req),
		.remote_wakeup_enable       (sc_q[UCS_SC_RWU_EN]),
		.wake_req                   (wake_req),
		.resume_signal              (resume_signal),
		.soft_reset_bit_set                 (soft_reset_bit_set),
		.ignored                    (ignored),
		.waking                     (waking),
		.remote_wakeup_request_flag (rwr_flag)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pin toward the local processor.

	logic src_any;

	// Bus reset and suspend sources gated by their own enables; every source gated by the global enable.
	always_comb begin
		src_any = sc_q[UCS_SC_GLOBAL_IE] &
			(ep_flag_any | missed_frame_start_flag |
			(bus_reset_flag & sc_q[UCS_SC_RESET_IE]) |
			(suspend_flag & sc_q[UCS_SC_SUSP_IE]));
	end

	ucs_irq_pin u_pin (
		.pclk       (pclk),
		.presetn    (presetn),
		.src_any    (src_any),
		.pulse_mode (sc_q[UCS_SC_PULSE_SEL]),
		.polarity   (sc_q[UCS_SC_POLARITY]),
		.pin        (interrupt_output_pin),
		.active     (pin_active)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sticky event status; a read clears only the bits that it returned, and a new event wins over the clear.

	always_comb begin
		pin_active_d                = pin_active;
		events                      = '0;
		events[UCS_EV_WAKE_DONE]    = soft_reset_bit_set;
		events[UCS_EV_PIN_IRQ]      = pin_active & ~pin_active_q;
		events[UCS_EV_IGNORED]      = ignored;
		st_d                        = (rd && hit_st) ? ((st_q & ~rdata_q[UCS_EV_WIDTH-1:0]) | events)
		                                             : (st_q | events);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q         <= UCS_EV_RESET;
			pin_active_q <= 1'b0;
		end else begin
			st_q         <= st_d;
			pin_active_q <= pin_active_d;
		end
	end

	assign irq = |(st_q & mk_q);

	////////////////////////////////////////////////////////////////////////////////
	// Read data is registered in the setup cycle and stands in the access cycle.

	always_comb begin
		rdata_d = rdata_q;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			if (hit_sc) begin
				rdata_d[7:0] = {sc_q[7:4], srst_q, sc_q[2:1], 1'b0};
			end else if (hit_st) begin
				rdata_d[UCS_EV_WIDTH-1:0] = st_q;
			end else if (hit_mk) begin
				rdata_d[UCS_EV_WIDTH-1:0] = mk_q;
			end else if (hit_ft) begin
				rdata_d[2:0] = ft_q;
			end else if (hit_cs) begin
				rdata_d[3:0] = {rwr_flag, suspended, waking, srst_q};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit_sc |-> (prdata[0] == 1'b0))
		else $error("reserved bit read back nonzero");

	a_awake_reset: assert property (@(posedge pclk) disable iff (!presetn)
		soft_write_one && !suspended && !waking |-> ##2 ctrl_reset)
		else $error("soft reset while awake did not reach reset");

	a_release_reset: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_sc && !pwdata[UCS_SC_SOFT_RST] && !soft_reset_bit_set |=> !ctrl_reset)
		else $error("writing zero did not release reset");

	a_suspend_noeffect: assert property (@(posedge pclk) disable iff (!presetn)
		soft_write_one && suspended && !ft_q[UCS_FT_EXT_FEAT] && !ctrl_reset && !waking
		|=> !ctrl_reset ##1 !ctrl_reset)
		else $error("soft reset acted while suspended");

	a_global_off: assert property (@(posedge pclk) disable iff (!presetn)
		!sc_q[UCS_SC_GLOBAL_IE] [*3] |-> !pin_active)
		else $error("interrupt signalled with global enable off");

	a_reset_ie_mask: assert property (@(posedge pclk) disable iff (!presetn)
		bus_reset_flag && !sc_q[UCS_SC_RESET_IE] && !ep_flag_any && !missed_frame_start_flag && !suspend_flag
		|-> !src_any)
		else $error("masked bus reset requested interrupt");

	// Further checks on the pin, the sequencer and the status register.

	sequence s_pulse_rise;
		sc_q[UCS_SC_PULSE_SEL] [*2] ##0 $rose(pin_active);
	endsequence

	sequence s_level_src;
		sc_q[UCS_SC_GLOBAL_IE] && !sc_q[UCS_SC_PULSE_SEL] && ep_flag_any;
	endsequence

	a_pulse_second: assert property (@(posedge pclk) disable iff (!presetn)
		s_pulse_rise |=> pin_active)
		else $error("pulse did not last a second clock");

	a_level_src_on: assert property (@(posedge pclk) disable iff (!presetn)
		s_level_src |=> pin_active)
		else $error("enabled endpoint flag did not reach the pin");

	a_level_release_pin: assert property (@(posedge pclk) disable iff (!presetn)
		!sc_q[UCS_SC_PULSE_SEL] && !src_any |=> !pin_active)
		else $error("level interrupt stayed active without a source");

	a_ignore_status: assert property (@(posedge pclk) disable iff (!presetn)
		soft_write_one && suspended && !ft_q[UCS_FT_EXT_FEAT] && !waking |=> ##1 st_q[UCS_EV_IGNORED])
		else $error("ignored soft reset write not reported");

	a_resume_local: assert property (@(posedge pclk) disable iff (!presetn)
		resume_signal |-> wake_req && $past(local_wakeup_req) && $past(sc_q[UCS_SC_RWU_EN]))
		else $error("resume sent without an enabled local request");

	a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reset && !(wr && hit_sc && !pwdata[UCS_SC_SOFT_RST]) |=> ctrl_reset)
		else $error("soft reset released without a zero write");

	a_reset_after_set: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ctrl_reset) |-> $past(soft_reset_bit_set))
		else $error("soft reset bit set before its request");

	a_wake_once: assert property (@(posedge pclk) disable iff (!presetn)
		wake_req && waking |=> !wake_req)
		else $error("soft reset wake-up requested twice");

	a_soft_wake_rwu: assert property (@(posedge pclk) disable iff (!presetn)
		soft_write_one && suspended && !waking && (ft_q == 3'h1) && !rwr_flag |=> !rwr_flag)
		else $error("soft reset wake-up set the remote wake-up request flag");

endmodule

// [tb/ucs_irq_sink.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
// Interrupt input of the local processor: it counts the edges at which the line is active.
module ucs_irq_sink (
	input  wire logic pclk,
	input  wire logic pin,
	input  wire logic active_high,
	output int        active_cnt
);
	// An active-low line is active at 0, an active-high line at 1.
	initial active_cnt = 0;
	always @(posedge pclk) begin
		if (pin === active_high) active_cnt <= active_cnt + 1;
	end
endmodule

// [tb/tb_usb_ctrl_sys_irq_softreset.sv]
`timescale 1ns/1ns
module tb_usb_ctrl_sys_irq_softreset;
	import ucs_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} ucs_tb_row_t;
	localparam logic [11:0] A_SC = {2'h0, UCS_IDX_SYS_CTRL, 2'h0};
	localparam logic [11:0] A_ST = {2'h0, UCS_IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MK = {2'h0, UCS_IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] A_FT = {2'h0, UCS_IDX_FEATURE, 2'h0};
	localparam logic [11:0] A_CS = {2'h0, UCS_IDX_CTRL_STAT, 2'h0};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        ep_flag_any, missed_frame_start_flag, bus_reset_flag, suspend_flag;
	logic        suspended, local_wakeup_req, interrupt_output_pin, ctrl_reset, wake_req, resume_signal, irq;
	logic        pol, e;
	int          error_cnt, compares, active_cnt, wake_cnt, resume_cnt, n0, n1;
	ucs_tb_row_t rows [5];
	////////////////////////////////////////////////////////////////
	ucs_sys_ctrl u_ucs_sys_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ep_flag_any(ep_flag_any), .missed_frame_start_flag(missed_frame_start_flag),
		.bus_reset_flag(bus_reset_flag), .suspend_flag(suspend_flag), .suspended(suspended),
		.local_wakeup_req(local_wakeup_req), .interrupt_output_pin(interrupt_output_pin),
		.ctrl_reset(ctrl_reset), .wake_req(wake_req), .resume_signal(resume_signal), .irq(irq));
	ucs_irq_sink u_ucs_irq_sink (.pclk(pclk), .pin(interrupt_output_pin), .active_high(pol),
		.active_cnt(active_cnt));
	////////////////////////////////////////////////////////////////
	// Clock of 20 ns and pulse counters for the one-cycle outputs.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial {wake_cnt, resume_cnt} = 0;
	always @(posedge pclk) begin
		if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
		if (resume_signal === 1'b1) resume_cnt <= resume_cnt + 1;
	end
	////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; the request stands until pready is seen high, for at most 50 clocks.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// Lets n edges pass and steps past their updates.
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task end_of_test;
		$display("Comparisons %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Cuts a hung run short.
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	// Main sequence: register table, then interrupt and soft reset cases.
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ep_flag_any, missed_frame_start_flag, bus_reset_flag, suspend_flag} = '0;
		{suspended, local_wakeup_req, pol} = '0;
		{error_cnt, compares} = 0;
		rows = '{'{A_SC, 32'hF5, 32'hF4}, '{A_SC, 32'h0, 32'h0}, '{A_MK, 32'h7, 32'h7},
			'{A_FT, 32'h7, 32'h7}, '{A_FT, 32'h0, 32'h0}};
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		chk("pin_idle", interrupt_output_pin, 1);
		rd(A_SC);
		chk("sc_reset", q, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk("reg_rw", q, rows[i].e);
		end
		rd(12'hFFC);
		chk("unmapped_err", e, 1);
		// Level mode, active low, global enable off then on.
		rd(A_ST);
		wr(A_MK, 32'h0);
		@(posedge pclk) ep_flag_any <= 1'b1;
		tick(3);
		chk("gie_off", interrupt_output_pin, 1);
		wr(A_SC, 32'h02);
		tick(2);
		chk("level_on", interrupt_output_pin, 0);
		chk("irq_masked", irq, 0);
		wr(A_MK, 32'h2);
		tick(1);
		chk("irq_unmasked", irq, 1);
		tick(4);
		chk("level_hold", interrupt_output_pin, 0);
		@(posedge pclk) ep_flag_any <= 1'b0;
		tick(3);
		chk("level_off", interrupt_output_pin, 1);
		rd(A_ST);
		chk("status_pin", q & 32'h2, 32'h2);
		tick(1);
		chk("irq_cleared", irq, 0);
		// Bus reset flag only with its own enable.
		@(posedge pclk) bus_reset_flag <= 1'b1;
		tick(3);
		chk("rst_ie_off", interrupt_output_pin, 1);
		wr(A_SC, 32'h12);
		tick(2);
		chk("rst_ie_on", interrupt_output_pin, 0);
		@(posedge pclk) bus_reset_flag <= 1'b0;
		// Pulse mode, active high: exactly two active edges.
		wr(A_SC, 32'h86);
		pol = 1'b1;
		tick(3);
		n0 = active_cnt;
		@(posedge pclk) missed_frame_start_flag <= 1'b1;
		tick(10);
		chk("pulse_len", active_cnt - n0, 2);
		@(posedge pclk) missed_frame_start_flag <= 1'b0;
		@(posedge pclk) suspend_flag <= 1'b1;
		wr(A_SC, 32'hA6);
		tick(10);
		chk("pulse_susp", active_cnt - n0, 4);
		@(posedge pclk) suspend_flag <= 1'b0;
		// Soft reset while awake, then release.
		wr(A_SC, 32'h08);
		tick(3);
		chk("srst_awake", ctrl_reset, 1);
		wr(A_SC, 32'h00);
		tick(2);
		chk("srst_release", ctrl_reset, 0);
		// Suspended without the feature: the write is ignored.
		@(posedge pclk) suspended <= 1'b1;
		wr(A_SC, 32'h08);
		tick(4);
		chk("srst_susp_ign", ctrl_reset, 0);
		rd(A_ST);
		chk("status_ign", q & 32'h4, 32'h4);
		wr(A_SC, 32'h00);
		// Power-off or low-output during suspend blocks the soft reset wake-up.
		n0 = wake_cnt;
		wr(A_FT, 32'h3);
		wr(A_SC, 32'h08);
		tick(4);
		chk("wake_po_block", wake_cnt - n0, 0);
		wr(A_SC, 32'h00);
		wr(A_FT, 32'h5);
		wr(A_SC, 32'h08);
		tick(4);
		chk("wake_loe_block", wake_cnt - n0, 0);
		wr(A_SC, 32'h00);
		// Self-powered product, so soft reset wake from suspend is used.
		wr(A_FT, 32'h1);
		rd(A_ST);
		n0 = wake_cnt;
		n1 = resume_cnt;
		wr(A_SC, 32'h08);
		tick(2);
		chk("wake_start", wake_cnt - n0, 1);
		chk("srst_delayed", ctrl_reset, 0);
		@(posedge pclk) suspended <= 1'b0;
		tick(3);
		chk("srst_after_wake", ctrl_reset, 1);
		chk("no_resume", resume_cnt - n1, 0);
		rd(A_ST);
		chk("status_wake", q & 32'h5, 32'h1);
		rd(A_CS);
		chk("rwu_flag_clear", q & 32'h8, 32'h0);
		wr(A_SC, 32'h00);
		tick(2);
		chk("wake_release", ctrl_reset, 0);
		// Local wake-up with remote wake-up enabled.
		wr(A_SC, 32'h40);
		@(posedge pclk) suspended <= 1'b1;
		@(posedge pclk) local_wakeup_req <= 1'b1;
		@(posedge pclk) local_wakeup_req <= 1'b0;
		tick(3);
		chk("local_resume", resume_cnt - n1, 1);
		rd(A_CS);
		chk("rwu_flag_set", q & 32'h8, 32'h8);
		@(posedge pclk) suspended <= 1'b0;
		tick(2);
		// Hardware reset in mid-run clears soft reset and the pin setup.
		wr(A_SC, 32'h8E);
		tick(3);
		chk("srst_pre", ctrl_reset, 1);
		@(posedge pclk) presetn <= 1'b0;
		tick(2);
		chk("rst_pin", interrupt_output_pin, 1);
		chk("rst_ctrl", ctrl_reset, 0);
		@(posedge pclk) presetn <= 1'b1;
		rd(A_SC);
		chk("rst_sc", q, 32'h0);
		end_of_test();
	end
endmodule
